// ==== dv/lowv_supervisor_bench.sv ====
// Self-checking bench for the low-voltage supervisor
`timescale 1ns/1ps
module lowv_supervisor_bench;
  import lowv_pkg::*;
  logic clk, rst, wr, rd, below_detect_level, below_reset_level, above_release_level;
  logic shared_reset_pin_i, shared_reset_pin_drive_low, shared_reset_pin_oe, aux_irq_event;
  logic sleep_instruction, global_irq_on_instruction, global_irq_off_instruction;
  logic instr_cycle_en, lowv_branch, wake_req, sys_reset, lowv_detector_enable;
  logic noise_reject_select, reset_pin_function_select, watchdog_period_select;
  logic [12:0] opt_word0, opt_word2;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [9:0]  lowv_branch_vector;
  logic [1:0]  brownout_level_select, lowv_threshold_select;
  logic [5:0]  customer_code_bits;
  logic        seen;
  int          mismatches, comparisons, cycles;

  lowv_supervisor lowv_supervisor_inst (
    .clk, .rst, .opt_word0, .opt_word2, .addr, .wdata, .wr, .rd, .rdata,
    .below_detect_level, .below_reset_level, .above_release_level, .shared_reset_pin_i,
    .shared_reset_pin_drive_low, .shared_reset_pin_o(), .shared_reset_pin_oe, .aux_irq_event,
    .sleep_instruction, .global_irq_on_instruction, .global_irq_off_instruction,
    .instr_cycle_en, .lowv_branch, .lowv_branch_vector, .wake_req, .sys_reset,
    .brownout_level_select, .lowv_threshold_select, .lowv_detector_enable,
    .noise_reject_select, .reset_pin_function_select, .watchdog_period_select,
    .customer_code_bits
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (e !== g) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr_reg(input logic [1:0] kind, input logic [1:0] idx, input logic [7:0] d);
    @(posedge clk);
    addr  <= {kind, idx};
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Data stand only in the cycle after the strobe, so sample just past that edge;
  // return on the next edge so that callers drive their inputs on an edge
  task automatic rd_chk(input logic [1:0] idx, input logic [7:0] e);
    @(posedge clk);
    addr <= {OP_WORD, idx};
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {2'h0, e}, {2'h0, rdata});
    @(posedge clk);
  endtask : rd_chk

  task automatic wait_hi(input bit wake);
    int n;
    n = 0;
    while ((wake ? wake_req : lowv_branch) !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(wake ? "wake" : "branch", 10'h001, {9'h0, wake ? wake_req : lowv_branch});
    @(posedge clk);
  endtask : wait_hi

  task automatic dip;
    below_detect_level <= 1'b0;
    cyc(4);
    below_detect_level <= 1'b1;
  endtask : dip

  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdata, below_detect_level, below_reset_level, aux_irq_event} = '0;
    {sleep_instruction, global_irq_on_instruction, global_irq_off_instruction} = '0;
    {above_release_level, shared_reset_pin_i, shared_reset_pin_drive_low} = 3'b111;
    opt_word0 = 13'h1800;
    opt_word2 = 13'h18C5;
    cyc(6);
    rst <= 1'b0;
    cyc(3);
    chk("opts", 10'h045, {1'b0, noise_reject_select, reset_pin_function_select,
        watchdog_period_select, customer_code_bits});
    rd_chk(CTRL_IDX, CTRL_RESET);
    rd_chk(MASK_IDX, MASK_RESET);
    rd_chk(STATUS_IDX, 8'h80);
    below_reset_level <= 1'b1;
    cyc(2100);
    chk("bor_off", 10'h000, {9'h0, sys_reset});
    below_reset_level <= 1'b0;
    wr_reg(OP_WORD, CTRL_IDX, 8'hFF);
    rd_chk(CTRL_IDX, 8'h0F);
    chk("thr_en", 10'h007, {7'h0, lowv_threshold_select, lowv_detector_enable});
    wr_reg(OP_CLEAR, CTRL_IDX, 8'h02);
    rd_chk(CTRL_IDX, 8'h0B);
    wr_reg(OP_SET, CTRL_IDX, 8'h02);
    rd_chk(CTRL_IDX, 8'h0F);
    below_detect_level <= 1'b1;
    cyc(4);
    rd_chk(STATUS_IDX, 8'h40);
    wr_reg(OP_WORD, STATUS_IDX, 8'hFF);
    rd_chk(STATUS_IDX, 8'h4B);
    wr_reg(OP_WORD, MASK_IDX, 8'h0F);
    rd_chk(STATUS_IDX, 8'h0B);
    wr_reg(OP_WORD, MASK_IDX, 8'hFF);
    wr_reg(OP_WORD, STATUS_IDX, 8'h0B);
    rd_chk(STATUS_IDX, 8'h0B);
    aux_irq_event <= 1'b1;
    @(posedge clk);
    aux_irq_event <= 1'b0;
    rd_chk(STATUS_IDX, 8'h2B);
    wr_reg(OP_CLEAR, STATUS_IDX, 8'h05);
    rd_chk(STATUS_IDX, 8'h0B);
    // Global enable on then off again: the flag alone must not branch
    @(posedge clk);
    global_irq_on_instruction <= 1'b1;
    @(posedge clk);
    global_irq_on_instruction  <= 1'b0;
    global_irq_off_instruction <= 1'b1;
    @(posedge clk);
    global_irq_off_instruction <= 1'b0;
    dip();
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      seen = seen | lowv_branch;
    end
    chk("no_branch", 10'h000, {9'h0, seen});
    @(posedge clk);
    global_irq_on_instruction <= 1'b1;
    @(posedge clk);
    global_irq_on_instruction <= 1'b0;
    wait_hi(1'b0);
    wr_reg(OP_WORD, STATUS_IDX, 8'h0B);
    sleep_instruction <= 1'b1;
    dip();
    wait_hi(1'b1);
    sleep_instruction  <= 1'b0;
    shared_reset_pin_i <= 1'b0;
    cyc(3);
    chk("pin_rst", 10'h001, {9'h0, sys_reset});
    shared_reset_pin_i <= 1'b1;
    cyc(3);
    chk("pin_free", 10'h000, {9'h0, sys_reset});
    rd_chk(STATUS_IDX, 8'h80);
    // Option words are static, so brownout and the general pin mode come in across a reset
    @(posedge clk);
    rst       <= 1'b1;
    opt_word0 <= 13'h0100;
    opt_word2 <= 13'h19C5;
    @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    rd_chk(STATUS_IDX, 8'h80);
    shared_reset_pin_i <= 1'b0;
    cyc(4);
    chk("pin_general", 10'h002, {8'h0, shared_reset_pin_oe, sys_reset});
    shared_reset_pin_i         <= 1'b1;
    shared_reset_pin_drive_low <= 1'b0;
    cyc(1);
    chk("pin_released", 10'h000, {9'h0, shared_reset_pin_oe});
    below_detect_level  <= 1'b0;
    below_reset_level   <= 1'b1;
    above_release_level <= 1'b0;
    cyc(1990);
    chk("bor_early", 10'h000, {9'h0, sys_reset});
    cyc(30);
    chk("bor_on", 10'h001, {9'h0, sys_reset});
    below_reset_level <= 1'b0;
    cyc(5);
    chk("bor_hold", 10'h001, {9'h0, sys_reset});
    above_release_level <= 1'b1;
    cyc(5);
    chk("bor_free", 10'h000, {9'h0, sys_reset});
    end_sim();
  end
endmodule : lowv_supervisor_bench

// ==== dv/lowv_supervisor_checker.sv ====
// Port-level assertions for the low-voltage supervisor
`timescale 1ns/1ps
module lowv_supervisor_checker
  import lowv_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [12:0]       opt_word0,
  input wire logic [12:0]       opt_word2,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              rd,
  input wire logic [7:0]        rdata,
  input wire logic              below_reset_level,
  input wire logic              shared_reset_pin_i,
  input wire logic              shared_reset_pin_drive_low,
  input wire logic              shared_reset_pin_oe,
  input wire logic              instr_cycle_en,
  input wire logic              lowv_branch,
  input wire logic [9:0]        lowv_branch_vector,
  input wire logic              wake_req,
  input wire logic              sys_reset,
  input wire logic [1:0]        brownout_level_select,
  input wire logic              noise_reject_select,
  input wire logic              watchdog_period_select,
  input wire logic [5:0]        customer_code_bits
);
  int bor_cnt_r;
  int bor_cnt_nxt;
  // Raw count of the brownout comparator; the design adds sync delay on top
  always_comb begin
    bor_cnt_nxt = bor_cnt_r;
    if (rst || !below_reset_level) begin
      bor_cnt_nxt = 0;
    end else if (bor_cnt_r < 4000) begin
      bor_cnt_nxt = bor_cnt_r + 1;
    end
  end
  always_ff @(posedge clk) begin
    bor_cnt_r <= bor_cnt_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_reset);
  chk_vector_fixed: assert property (lowv_branch_vector == LOWV_VECTOR)
    else $error("branch vector wrong");
  chk_branch_on_cycle: assert property (lowv_branch |-> instr_cycle_en)
    else $error("branch outside instruction cycle");
  chk_cycle_two_clk: assert property (
    !opt_word0[8] && instr_cycle_en |=> !instr_cycle_en ##1 instr_cycle_en)
    else $error("instruction cycle spacing wrong");
  chk_cycle_four_clk: assert property (
    opt_word0[8] && instr_cycle_en |=> !instr_cycle_en [*3] ##1 instr_cycle_en)
    else $error("four-period instruction cycle spacing wrong");
  chk_ctrl_upper_zero: assert property (
    rd && addr[1:0] == CTRL_IDX |=> rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_pin_oe_mode: assert property (
    shared_reset_pin_oe == (opt_word2[8] & shared_reset_pin_drive_low))
    else $error("reset pin drive wrong");
  chk_noise_wdt_decode: assert property (
    noise_reject_select == opt_word2[9] && watchdog_period_select == opt_word2[6])
    else $error("option word 2 decode wrong");
  chk_code_decode: assert property (customer_code_bits == opt_word2[5:0])
    else $error("customer code wrong");
  chk_bor_level_decode: assert property (brownout_level_select == opt_word0[12:11])
    else $error("brownout level decode wrong");
  chk_wake_one_cycle: assert property (wake_req |=> !wake_req)
    else $error("wake request too long");
  chk_reset_forces_sys: assert property (disable iff (1'b0) rst |-> sys_reset)
    else $error("system reset missing");
  chk_bor_filter_time: assert property (
    disable iff (rst) $rose(sys_reset) && shared_reset_pin_i |-> bor_cnt_r >= 2000)
    else $error("brownout reset too early");
  cov_branch: cover property (lowv_branch);
  cov_wake: cover property (wake_req);
  cov_bor: cover property (disable iff (rst) $rose(sys_reset));
endmodule : lowv_supervisor_checker

bind lowv_supervisor lowv_supervisor_checker #(.ADDR_W(ADDR_W)) lowv_supervisor_checker_inst (
  .clk, .rst, .opt_word0, .opt_word2, .addr, .rd, .rdata, .below_reset_level,
  .shared_reset_pin_i, .shared_reset_pin_drive_low, .shared_reset_pin_oe, .instr_cycle_en,
  .lowv_branch, .lowv_branch_vector, .wake_req, .sys_reset, .brownout_level_select,
  .noise_reject_select, .watchdog_period_select, .customer_code_bits
);

// ==== shared/lowv_pkg.sv ====
// Constants shared by the low-voltage supervision block
package lowv_pkg;
  // Register indices on the local port (addr[1:0])
  localparam logic [1:0] CTRL_IDX   = 2'h0;
  localparam logic [1:0] STATUS_IDX = 2'h1;
  localparam logic [1:0] MASK_IDX   = 2'h2;
  localparam logic [1:0] OPT_IDX    = 2'h3;
  // Access kinds on the local port (addr[3:2])
  localparam logic [1:0] OP_WORD  = 2'h0;
  localparam logic [1:0] OP_SET   = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  // Control register fields
  localparam int CTRL_IE_BIT  = 3;
  localparam int CTRL_EN_BIT  = 2;
  localparam int CTRL_THR_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h0F;
  // Status and wake control register fields
  localparam int ST_STATE_N_BIT = 7;
  localparam int ST_FLAG_BIT    = 6;
  localparam int ST_AUX_BIT     = 5;
  localparam int ST_AUX_WE3_BIT = 3;
  localparam int ST_AUX_WE1_BIT = 1;
  localparam int ST_WAKE_BIT    = 0;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  // Option word 0 fields
  localparam int OPT0_BOR_LSB = 11;
  localparam int OPT0_INSTRUCTION_PERIOD_SELECT_BIT = 8;
  localparam logic [1:0] BOR_POR_ONLY = 2'h3;
  // Option word 2 fields
  localparam int OPT2_NRM_BIT   = 9;
  localparam int OPT2_RSTEN_BIT = 8;
  localparam int OPT2_WDT_BIT   = 6;
  localparam int OPT2_ID_LSB    = 0;
  localparam int OPT2_ID_W      = 6;
  // Interrupt vector of the detector
  localparam logic [9:0] LOWV_VECTOR = 10'h021;
  // Timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int BOR_FILTER_NS  = 10000;
  localparam int BOR_FILTER_CYC = (BOR_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BOR_CNT_W      = $clog2(BOR_FILTER_CYC + 1);
  typedef enum logic [1:0] {
    BOR_OK   = 2'b00,
    BOR_FILT = 2'b01,
    BOR_HOLD = 2'b11
  } bor_state_e;
endpackage : lowv_pkg

// ==== src/lowv_supervisor.sv ====
// Low-voltage detector, brownout reset and option word decode
//
// Functional notes
// - Option word 2 bit 9 selects noise rejection: 0 mode 2, 1 mode 1.
// - Option word 2 bit 8: 0 reset pin is reset input, 1 general pin.
// - Option word 2 bit 6: 1 gives 18 ms watchdog, 0 gives 4.5 ms.
// - Option word 2 bits 5..0 are a customer code with no effect.
// - Supply below reset level 10 us enters reset until above release.
// - Option word 0 bits 12..11 pick brownout levels; 11 means disabled.
// - Control bit 2 enables the low-voltage detector.
// - Control bit 3 enables the detector interrupt; readable and writable.
// - Control bits 1..0 pick detection threshold 2.2/3.3/4.0/4.5 V.
// - Status bit 7 reads 0 while supply below threshold, else 1; here it also reads 1 while the detector is disabled or idle in sleep.
// - Status bit 6 flag sets on drop; software may only clear bits 6,5, never set them.
// - Status register reads as contents ANDed with the mask register.
// - With wake enable, detector runs in sleep, sets flag and wakes.
// - Any system reset clears the low-voltage flag.
// - Flag, enable and global enable branch to vector 021H next.
// - Enable and disable instructions switch global interrupts.
// - Instructions are 13-bit words, one cycle of two or four periods.
// - Control bits 3..0, mask bits and status bits 3,1,0 may be set, cleared and tested directly.
// - Option word 0 bit 8: 0 two periods per cycle, 1 four.
`timescale 1ns/1ps
module lowv_supervisor
  import lowv_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [12:0]       opt_word0,
  input  wire logic [12:0]       opt_word2,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic              below_detect_level,
  input  wire logic              below_reset_level,
  input  wire logic              above_release_level,
  input  wire logic              shared_reset_pin_i,
  input  wire logic              shared_reset_pin_drive_low,
  output logic                   shared_reset_pin_o,
  output logic                   shared_reset_pin_oe,
  input  wire logic              aux_irq_event,
  input  wire logic              sleep_instruction,
  input  wire logic              global_irq_on_instruction,
  input  wire logic              global_irq_off_instruction,
  output logic                   instr_cycle_en,
  output logic                   lowv_branch,
  output logic      [9:0]        lowv_branch_vector,
  output logic                   wake_req,
  output logic                   sys_reset,
  output logic      [1:0]        brownout_level_select,
  output logic      [1:0]        lowv_threshold_select,
  output logic                   lowv_detector_enable,
  output logic                   noise_reject_select,
  output logic                   reset_pin_function_select,
  output logic                   watchdog_period_select,
  output logic      [5:0]        customer_code_bits
);

  // Synchronisers for asynchronous comparator and pin levels
  localparam int NSYNC = 4;
  // Reset to the idle level of each input: a zero on the pin bit would
  // fake a pin reset for two cycles after every release of rst
  localparam logic [NSYNC-1:0] SYNC_IDLE = 4'hC;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] async_in;
  assign async_in = {shared_reset_pin_i, above_release_level,
                     below_reset_level, below_detect_level};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync1_r[gi] <= SYNC_IDLE[gi];
          sync2_r[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic below_det_s;
  logic below_rst_s;
  logic above_rel_s;
  logic pin_level_s;
  assign below_det_s = sync2_r[0];
  assign below_rst_s = sync2_r[1];
  assign above_rel_s = sync2_r[2];
  assign pin_level_s = sync2_r[3];

  // Option word decode; option words are static after power-up
  assign noise_reject_select       = opt_word2[OPT2_NRM_BIT];
  assign reset_pin_function_select = opt_word2[OPT2_RSTEN_BIT];
  assign watchdog_period_select    = opt_word2[OPT2_WDT_BIT];
  assign customer_code_bits = opt_word2[OPT2_ID_LSB +: OPT2_ID_W];
  assign brownout_level_select = opt_word0[OPT0_BOR_LSB +: 2];

  // Shared reset pin: open-drain only when used as a general pin
  assign shared_reset_pin_o  = 1'b0;
  assign shared_reset_pin_oe = reset_pin_function_select
                               & shared_reset_pin_drive_low;

  // Brownout reset filter and hold
  bor_state_e            bor_r;
  bor_state_e            bor_nxt;
  logic [BOR_CNT_W-1:0]  bor_cnt_r;
  logic [BOR_CNT_W-1:0]  bor_cnt_nxt;
  logic                  bor_enabled;
  assign bor_enabled = (brownout_level_select != BOR_POR_ONLY);

  always_comb begin
    bor_nxt     = bor_r;
    bor_cnt_nxt = bor_cnt_r;
    unique case (bor_r)
      BOR_OK: begin
        bor_cnt_nxt = '0;
        if (bor_enabled && below_rst_s) begin
          bor_nxt = BOR_FILT;
        end
      end
      BOR_FILT: begin
        if (!bor_enabled || !below_rst_s) begin
          bor_nxt = BOR_OK;
        // One cycle goes to entering the filter, so the count ends two short
        end else if (bor_cnt_r == BOR_CNT_W'(BOR_FILTER_CYC - 2)) begin
          bor_nxt = BOR_HOLD;
        end else begin
          bor_cnt_nxt = bor_cnt_r + 1'b1;
        end
      end
      BOR_HOLD: begin
        // Held until the supply is back above the release level
        if (!bor_enabled || (above_rel_s && !below_rst_s)) begin
          bor_nxt = BOR_OK;
        end
      end
      default: begin
        bor_nxt = BOR_OK;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bor_r     <= BOR_OK;
      bor_cnt_r <= '0;
    end else begin
      bor_r     <= bor_nxt;
      bor_cnt_r <= bor_cnt_nxt;
    end
  end

  logic pin_reset;
  assign pin_reset = !reset_pin_function_select && !pin_level_s;
  // Pin and brownout resets arrive through the synchronisers, two cycles late
  assign sys_reset = rst || (bor_r == BOR_HOLD) || pin_reset;

  // Instruction cycle enable from the oscillator clock
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic       four_per_cycle;
  assign four_per_cycle = opt_word0[OPT0_INSTRUCTION_PERIOD_SELECT_BIT];

  always_comb begin
    div_nxt = div_r + 2'h1;
    if (instr_cycle_en) begin
      div_nxt = 2'h0;
    end
  end

  // Two periods per cycle by default on this path, four when selected
  assign instr_cycle_en = four_per_cycle ? (div_r == 2'h3)
                                         : (div_r == 2'h1);

  always_ff @(posedge clk) begin
    if (sys_reset) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Register access decode
  logic [1:0] reg_idx;
  logic [1:0] acc_op;
  logic [7:0] bit_sel;
  assign reg_idx = addr[1:0];
  assign acc_op  = addr[3:2];
  assign bit_sel = 8'h01 << wdata[2:0];

  // Value a write access would leave in a register
  function automatic logic [7:0] apply_write(input logic [7:0] cur,
                                             input logic [1:0] op,
                                             input logic [7:0] wd,
                                             input logic [7:0] bsel);
    logic [7:0] res;
    res = cur;
    unique case (op)
      OP_WORD:  res = wd;
      OP_SET:   res = cur | bsel;
      OP_CLEAR: res = cur & ~bsel;
      default:  res = cur;
    endcase
    return res;
  endfunction : apply_write

  // Control, mask and status storage
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       aux_flag_r;
  logic       aux_flag_nxt;
  logic [2:0] wake_en_r;
  logic [2:0] wake_en_nxt;
  logic       gie_r;
  logic       gie_nxt;
  logic       below_prev_r;
  logic       below_prev_nxt;
  logic [7:0] status_raw;
  logic [7:0] status_new;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_mask;

  assign lowv_threshold_select = ctrl_r[CTRL_THR_LSB +: 2];
  assign lowv_detector_enable  = ctrl_r[CTRL_EN_BIT];

  assign wr_ctrl = wr && (reg_idx == CTRL_IDX);
  assign wr_stat = wr && (reg_idx == STATUS_IDX);
  assign wr_mask = wr && (reg_idx == MASK_IDX);

  // Detector activity: in sleep it runs only with wake enabled
  logic det_active;
  logic below_now;
  logic drop_event;
  assign det_active = lowv_detector_enable
                      && (!sleep_instruction || wake_en_r[0]);
  assign below_now  = det_active && below_det_s;
  // Edge, not level: a supply that stays low sets the flag only once
  assign drop_event = below_now && !below_prev_r;

  logic state_n;
  assign state_n = !below_now;

  always_comb begin
    status_raw = 8'h00;
    status_raw[ST_STATE_N_BIT] = state_n;
    status_raw[ST_FLAG_BIT]    = flag_r;
    status_raw[ST_AUX_BIT]     = aux_flag_r;
    status_raw[ST_AUX_WE3_BIT] = wake_en_r[2];
    status_raw[ST_AUX_WE1_BIT] = wake_en_r[1];
    status_raw[ST_WAKE_BIT]    = wake_en_r[0];
  end

  assign status_new = apply_write(status_raw, acc_op, wdata, bit_sel);

  always_comb begin
    ctrl_nxt       = ctrl_r;
    mask_nxt       = mask_r;
    flag_nxt       = flag_r;
    aux_flag_nxt   = aux_flag_r;
    wake_en_nxt    = wake_en_r;
    gie_nxt        = gie_r;
    below_prev_nxt = below_now;
    if (wr_ctrl) begin
      ctrl_nxt = apply_write(ctrl_r, acc_op, wdata, bit_sel)
                 & CTRL_WMASK;
    end
    if (wr_mask) begin
      mask_nxt = apply_write(mask_r, acc_op, wdata, bit_sel);
    end
    if (wr_stat) begin
      // Flags may only be cleared; state bit is read-only
      flag_nxt     = flag_r & status_new[ST_FLAG_BIT];
      aux_flag_nxt = aux_flag_r & status_new[ST_AUX_BIT];
      wake_en_nxt  = {status_new[ST_AUX_WE3_BIT],
                      status_new[ST_AUX_WE1_BIT],
                      status_new[ST_WAKE_BIT]};
    end
    // A hardware set in the same cycle as a clear wins
    if (drop_event) begin
      flag_nxt = 1'b1;
    end
    if (aux_irq_event) begin
      aux_flag_nxt = 1'b1;
    end
    if (global_irq_on_instruction) begin
      gie_nxt = 1'b1;
    end
    // Taking the branch drops global enable, as interrupt entry does
    if (global_irq_off_instruction || lowv_branch) begin
      gie_nxt = 1'b0;
    end
  end

  // System reset, brownout and pin reset included, clears the flags
  always_ff @(posedge clk) begin
    if (sys_reset) begin
      ctrl_r       <= CTRL_RESET;
      mask_r       <= MASK_RESET;
      flag_r       <= 1'b0;
      aux_flag_r   <= 1'b0;
      wake_en_r    <= 3'h0;
      gie_r        <= 1'b0;
      below_prev_r <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      mask_r       <= mask_nxt;
      flag_r       <= flag_nxt;
      aux_flag_r   <= aux_flag_nxt;
      wake_en_r    <= wake_en_nxt;
      gie_r        <= gie_nxt;
      below_prev_r <= below_prev_nxt;
    end
  end

  // Branch request at the next instruction boundary
  assign lowv_branch = instr_cycle_en && flag_r && ctrl_r[CTRL_IE_BIT]
                       && gie_r;
  assign lowv_branch_vector = LOWV_VECTOR;

  // Wake from sleep on the drop when wake is enabled
  logic wake_nxt;
  logic wake_r;
  assign wake_nxt = sleep_instruction && wake_en_r[0] && drop_event;
  always_ff @(posedge clk) begin
    if (sys_reset) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end
  assign wake_req = wake_r;

  // Read data, valid the cycle after the read strobe only
  // Cleared by rst only; with no read pending it holds 0 anyway
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      unique case (reg_idx)
        CTRL_IDX:   rdata_nxt = ctrl_r & CTRL_WMASK;
        STATUS_IDX: rdata_nxt = status_raw & mask_r;
        MASK_IDX:   rdata_nxt = mask_r;
        OPT_IDX:    rdata_nxt = {2'h0, customer_code_bits};
        default:    rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

endmodule : lowv_supervisor
